// ==== dv/spi_host_model.sv ====
// Host model that drives the serial command port pins in modes 0,0 and 1,1
`timescale 1ns/1ps
module spi_host_model import spi_restart_pkg::*; (
    input wire logic sys_clk,
    output spi_pins_t pins,
    input spi_drive_t drv
);
    logic mode3 = 1'b0;
    logic last_sdo = 1'b0;
    logic sdo_line;
    initial pins = '{cs_n: 1'b1, sck: 1'b0, sdi: 1'b0};
    // Released output line shows a changing pattern, never the last value
    assign sdo_line = drv.sdo_oe ? drv.sdo : ~last_sdo;
    always @(posedge sys_clk) last_sdo <= sdo_line;
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #5;
    endtask
    task automatic start(input logic m3);
        mode3 = m3;
        pins.sck = m3;
        tick(4);
        pins.cs_n = 1'b0;
        tick(6);
    endtask
    task automatic xbyte(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            pins.sck = 1'b0;
            pins.sdi = tx[i];
            tick(4);
            pins.sck = 1'b1;
            rx[i] = sdo_line;
            tick(4);
        end
    endtask
    task automatic stop();
        if (!mode3) pins.sck = 1'b0;
        tick(4);
        pins.cs_n = 1'b1;
        tick(6);
    endtask
    task automatic idle_noise();
        repeat (4) begin
            pins.sck = ~pins.sck;
            pins.sdi = ~pins.sdi;
            tick(4);
        end
    endtask
endmodule // spi_host_model

// ==== dv/spi_restart_ctrl_tb.sv ====
// Self-checking bench of the serial command port and restart control
`timescale 1ns/1ps
`include "spi_restart_defs.svh"
`define CHECK(got, exp) begin total_checks++; if ((got) !== (exp)) begin fails++; \
    $display("Error at %0t: got %h expected %h", $time, (got), (exp)); end end
module spi_restart_ctrl_tb import spi_restart_pkg::*;;
    localparam logic [1:0] ID = 2'h1;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic clock_aligned = 1'b1;
    logic scan_in_gap = 1'b0;
    logic data_ready_flag = 1'b0;
    spi_pins_t pins;
    spi_drive_t drv;
    conv_ctl_t ctl;
    logic single_channel_mode, start_pulse_enable, config_checksum_error_flag;
    logic [7:0] primary_settings_reg;
    logic [1:0] bias_current_scale;
    int fails = 0, total_checks = 0, cycles = 0, starts = 0, gap = 0, last_gap = 0;
    int fcnt[3] = '{0, 0, 0};
    int f0[3];
    logic last_scan = 1'b0, last_sp = 1'b0, m3 = 1'b0, sp_on = 1'b0;
    logic [7:0] st;
    logic [7:0] rxb[3];
    spi_restart_ctrl #(.CHIP_ID(ID)) spi_restart_ctrl_i (.sys_clk(sys_clk), .rst_n(rst_n), .pins(pins),
        .clock_aligned(clock_aligned), .scan_in_gap(scan_in_gap), .data_ready_flag(data_ready_flag),
        .drv(drv), .ctl(ctl), .single_channel_mode(single_channel_mode), .start_pulse_enable(start_pulse_enable),
        .config_checksum_error_flag(config_checksum_error_flag), .primary_settings_reg(primary_settings_reg),
        .bias_current_scale(bias_current_scale));
    spi_host_model spi_host_model_i (.sys_clk(sys_clk), .pins(pins), .drv(drv));
    initial forever #25 sys_clk = ~sys_clk;
    task automatic report_and_stop();
        if (fails == 0 && total_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // Interval from abort to start, scan flag and fast command pulses
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        gap <= ctl.conv_abort ? 1 : gap + 1;
        fcnt[0] <= fcnt[0] + int'(ctl.fast_start);
        fcnt[1] <= fcnt[1] + int'(ctl.fast_standby);
        fcnt[2] <= fcnt[2] + int'(ctl.fast_adc_off);
        if (ctl.conv_start) begin
            starts <= starts + 1;
            last_gap <= gap;
            last_scan <= ctl.scan_restart;
            last_sp <= ctl.start_pulse;
        end
        if (cycles == 60000) begin
            fails++;
            report_and_stop();
        end
    end
    function automatic logic [15:0] crc16(input logic [7:0] d);
        logic [15:0] c;
        c = `CRC_INIT;
        for (int i = 7; i >= 0; i--) c = {c[14:0], 1'b0} ^ ((c[15] ^ d[i]) ? `CRC_POLY : 16'h0000);
        return c;
    endfunction
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #5;
    endtask
    task automatic xfer(input logic [7:0] cmd, input logic [7:0] wd, input int n);
        spi_host_model_i.start(m3);
        spi_host_model_i.xbyte(cmd, st);
        for (int i = 0; i < n; i++) spi_host_model_i.xbyte(wd, rxb[i]);
        spi_host_model_i.stop();
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        xfer({ID, a, `CMD_INC_WR}, d, 1);
    endtask
    // Write and expect a restart after g cycles, or none when g is zero
    task automatic wr_exp(input logic [3:0] a, input logic [7:0] d, input int g, input logic sc);
        int s0;
        s0 = starts;
        wr(a, d);
        if (g == 0) begin
            tick(300);
            `CHECK(starts, s0)
        end else begin
            for (int k = 0; k < 600 && starts == s0; k++) tick(1);
            `CHECK(starts, s0 + 1)
            `CHECK(last_gap, g)
            `CHECK({last_scan, last_sp}, {sc, sp_on})
        end
    endtask
    initial begin
        repeat (12) @(posedge sys_clk);
        #5 rst_n = 1'b1;
        tick(3);
        `CHECK({drv.sdo_oe, ctl, primary_settings_reg, single_channel_mode}, {1'b0, 8'h00, 8'h00, 1'b1})
        spi_host_model_i.idle_noise();
        `CHECK(drv.sdo_oe, 1'b0)
        data_ready_flag = 1'b1;
        xfer({ID, `REG_PRIMARY, `CMD_STATIC_RD}, 8'h00, 1);
        `CHECK(st, {2'b00, ID, ~ID[0], 3'b100})
        `CHECK(rxb[0], 8'h00)
        for (int c = 10; c < 16; c++) begin
            f0 = fcnt;
            xfer({ID, c[3:0], `CMD_FAST}, 8'h00, 0);
            tick(20);
            `CHECK({fcnt[0] != f0[0], fcnt[1] != f0[1], fcnt[2] != f0[2]}, (c < 13) ? 3'b100 >> (c - 10) : 0)
        end
        tick(300);
        sp_on = 1'b1;
        wr(`REG_DIGITAL, 8'h02);
        `CHECK(st, {2'b00, ID, ~ID[0], 3'b101})
        `CHECK(start_pulse_enable, 1'b1)
        wr_exp(`REG_PRIMARY, 8'h5A, 258, 1'b0);
        `CHECK(primary_settings_reg, 8'h5A)
        wr_exp(`REG_BIAS, 8'h00, 2, 1'b0);
        wr_exp(`REG_BIAS, 8'hC0, 258, 1'b0);
        `CHECK(bias_current_scale, 2'h3)
        wr_exp(`REG_RSVD_B, 8'h11, 258, 1'b0);
        clock_aligned = 1'b0;
        wr_exp(`REG_RSVD_C, 8'h22, 260, 1'b0);
        clock_aligned = 1'b1;
        xfer({ID, `FAST_STANDBY, `CMD_FAST}, 8'h00, 0);
        tick(300);
        wr_exp(`REG_PRIMARY, 8'h5B, 258, 1'b0);
        wr_exp(`REG_TIMER, 8'h10, 0, 1'b0);
        wr_exp(`REG_SEQUENCER, 8'h00, 0, 1'b0);
        wr_exp(`REG_SEQUENCER, 8'h80, 2, 1'b1);
        `CHECK(single_channel_mode, 1'b0)
        wr_exp(`REG_SEQUENCER, 8'h81, 2, 1'b1);
        wr_exp(`REG_TIMER, 8'h20, 0, 1'b0);
        wr_exp(`REG_PRIMARY, 8'h5C, 258, 1'b0);
        scan_in_gap = 1'b1;
        wr_exp(`REG_TIMER, 8'h30, 2, 1'b1);
        wr_exp(`REG_SEQUENCER, 8'h82, 0, 1'b0);
        scan_in_gap = 1'b0;
        for (int m = 0; m < 2; m++) begin
            m3 = m[0];
            xfer({ID, `REG_PRIMARY, `CMD_INC_RD}, 8'h00, 3);
            `CHECK({rxb[0], rxb[1], rxb[2]}, 24'h5CC002)
        end
        m3 = 1'b0;
        wr(`REG_DIGITAL, 8'h03);
        xfer({ID, `REG_PRIMARY, `CMD_STATIC_RD}, 8'h00, 3);
        `CHECK({rxb[0], rxb[1], rxb[2]}, {8'h5C, crc16(8'h5C)})
        xfer({~ID, `REG_PRIMARY, `CMD_INC_WR}, 8'h77, 1);
        `CHECK({st[7:6], primary_settings_reg}, {2'b00, 8'h5C})
        wr(`REG_LOCK, 8'h00);
        wr_exp(`REG_PRIMARY, 8'h66, 0, 1'b0);
        `CHECK({primary_settings_reg, config_checksum_error_flag}, {8'h5C, 1'b0})
        wr(`REG_LOCK, 8'h01);
        tick(40);
        `CHECK(config_checksum_error_flag, 1'b1)
        wr(`REG_LOCK, `UNLOCK_KEY);
        `CHECK(st, {2'b00, ID, ~ID[0], 3'b111})
        wr_exp(`REG_PRIMARY, 8'h66, 258, 1'b0);
        report_and_stop();
    end
endmodule // spi_restart_ctrl_tb

// ==== hdl/spi_restart_ctrl.sv ====
// Serial command port with write lock, CRC protection and conversion restart control
`timescale 1ns/1ps
`include "spi_restart_defs.svh"
// Contract
// R1: Delayed write aborts, waits two clocks, then setup
// R2: Delayed group: primary top, clocks, bias, reserved
// R3: Unchanged clock/bias rewrite restarts without setup
// R4: Scan mode: restart only current conversion
// R5: Setup delay applies even in standby
// R6: Restart resets divider phases, aligns to clock
// R7: Start pulse when restarted conversion begins
// R8: Resynchronisation wait may stretch to four clocks
// R9: Single-channel: sequencer writes restart only entering scan
// R10: Scan running: sequencer write restarts, timer not
// R11: Scan gap: timer write restarts, sequencer not
// R12: Modes 0,0 and 1,1; out falling, in rising
// R13: Serial logic reset at power-on, own timing
// R14: Chip select high: output off, inputs ignored
// R15: Host changes mode only with chip select high
// R16: Writes ignored unless lock key equals A5; the lock register itself is still written while locked
// R17: Reads end with CRC-16 when enabled
// R18: Locked: background register CRC, flag on change
// R19: Command byte first, then data or nothing
// R20: Status byte shifts out during command byte
// R21: Command: id 7:6, address 5:2, type 1:0
// R22: Id mismatch ignores command, output stays off
// R23: Fast codes A to E; others ignored
// R24: Types: static read, incremental write, incremental read
// R25: Status: 0,0, id, inverted id LSB, flags
// R26: Write events pass a synchroniser first
module spi_restart_ctrl import spi_restart_pkg::*; #(
    parameter logic [1:0] CHIP_ID = 2'h1 // Arbitrary value
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input spi_pins_t pins,
    input wire logic clock_aligned,
    input wire logic scan_in_gap,
    input wire logic data_ready_flag,
    output spi_drive_t drv,
    output conv_ctl_t ctl,
    output logic single_channel_mode,
    output logic start_pulse_enable,
    output logic config_checksum_error_flag,
    output logic [7:0] primary_settings_reg,
    output logic [1:0] bias_current_scale
);
    state_t s, next_s;

    function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] d);
        logic [15:0] r;
        r = c ^ {d, 8'h00};
        for (int i = 0; i < 8; i++) begin
            r = r[15] ? ((r << 1) ^ `CRC_POLY) : (r << 1);
        end
        return r;
    endfunction

    function automatic logic [7:0] reg_read(input state_t st, input logic [3:0] a);
        case (a)
            `REG_DATA: reg_read = 8'h00;
            `REG_CFG_CRC_HI: reg_read = st.cfg_crc[15:8];
            `REG_CFG_CRC_LO: reg_read = st.cfg_crc[7:0];
            default: reg_read = st.regs[a];
        endcase
    endfunction

    function automatic logic [15:0][7:0] reg_defaults();
        logic [15:0][7:0] r;
        r = {16{`REG_RESET}};
        r[`REG_LOCK] = `LOCK_RESET;
        return r;
    endfunction

    logic rise, fall, byte_done, id_bad, wr_ok, scan_on, locked;
    logic ev, ev_delay, ev_scan;
    logic [7:0] rx, old;
    logic [15:0] crc_n;

    always_comb begin
        next_s = s;
        ev = 1'b0;
        ev_delay = 1'b0;
        ev_scan = 1'b0;
        rx = {s.shin[6:0], s.sdi_s2};
        old = s.regs[s.addr];
        crc_n = s.crc_tx;
        next_s.ctl = '0;
        // Pins pass two flip-flops before any edge logic looks at them
        next_s.cs_s1 = pins.cs_n; // R26
        next_s.cs_s2 = s.cs_s1; // R26
        next_s.sck_s1 = pins.sck;
        next_s.sck_s2 = s.sck_s1;
        next_s.sdi_s1 = pins.sdi;
        next_s.sdi_s2 = s.sdi_s1;
        next_s.cs_q = s.cs_s2;
        next_s.sck_q = s.sck_s2;
        rise = s.sck_s2 & ~s.sck_q;
        fall = ~s.sck_s2 & s.sck_q;
        byte_done = rise && (s.bitcnt == 3'd7);
        id_bad = rise && (s.phase == PH_CMD) && (s.bitcnt == 3'd1) && ({s.shin[0], s.sdi_s2} != CHIP_ID); // R22
        locked = (s.regs[`REG_LOCK] != `UNLOCK_KEY);
        wr_ok = (!locked || s.addr == `REG_LOCK) && s.addr != `REG_DATA && s.addr < `REG_CFG_CRC_HI; // R16
        scan_on = s.regs[`REG_SEQUENCER][`FLD_SEQ_EN];
        if (s.cs_s2) begin
            // Deselected: output off and serial state cleared
            next_s.phase = PH_CMD; // R14
            next_s.bitcnt = 3'd0;
            next_s.got_rise = 1'b0;
            next_s.drv = '0; // R14
        end else if (s.cs_q) begin
            next_s.drv = '{sdo: 1'b0, sdo_oe: 1'b1}; // R25
            next_s.shout = {2'b00, CHIP_ID, ~CHIP_ID[0], data_ready_flag, s.cfg_err, s.por_flag} << 1; // R20 R25
        end else begin
            if (rise) begin
                // Input bits are taken on the rising edge
                next_s.shin = rx; // R12
                next_s.bitcnt = s.bitcnt + 3'd1;
                next_s.got_rise = 1'b1;
            end
            if (id_bad) begin
                next_s.phase = PH_IGNORE; // R22
                next_s.drv.sdo_oe = 1'b0;
            end
            if (byte_done) begin
                case (s.phase)
                    PH_CMD: begin
                        next_s.addr = rx[5:2]; // R21
                        next_s.crc_tx = `CRC_INIT;
                        next_s.rd_static = (rx[1:0] == `CMD_STATIC_RD);
                        case (rx[1:0]) // R24
                            `CMD_FAST: begin
                                next_s.phase = PH_IGNORE; // R19
                                next_s.drv.sdo_oe = 1'b0; // R19
                                case (rx[5:2]) // R23
                                    `FAST_START: next_s.ctl.fast_start = 1'b1;
                                    `FAST_STANDBY: next_s.ctl.fast_standby = 1'b1;
                                    `FAST_ADC_OFF: next_s.ctl.fast_adc_off = 1'b1;
                                    `FAST_FULL_OFF: next_s.regs[`REG_PRIMARY] = 8'h00;
                                    `FAST_FULL_RESET: begin
                                        next_s.regs = reg_defaults();
                                        next_s.por_flag = 1'b1;
                                    end
                                    default: ;
                                endcase
                            end
                            `CMD_INC_WR: next_s.phase = PH_WR;
                            default: begin
                                next_s.phase = PH_RD;
                                next_s.shout = reg_read(s, rx[5:2]);
                                next_s.crc_tx = crc_byte(`CRC_INIT, reg_read(s, rx[5:2])); // R17
                            end
                        endcase
                    end
                    PH_WR: begin
                        next_s.addr = s.addr + 4'd1;
                        if (wr_ok) begin
                            next_s.regs[s.addr] = rx; // R16
                            case (s.addr)
                                `REG_PRIMARY, `REG_RSVD_B, `REG_RSVD_C: begin
                                    ev = 1'b1; // R2
                                    ev_delay = 1'b1; // R2
                                end
                                `REG_BIAS: begin
                                    ev = 1'b1;
                                    ev_delay = (rx[`FLD_BIAS_HI:`FLD_BIAS_LO] != old[`FLD_BIAS_HI:`FLD_BIAS_LO]); // R3
                                end
                                `REG_SEQUENCER: begin
                                    // Entering scan or writing it mid-cycle restarts the whole sequence
                                    ev = scan_on ? !scan_in_gap : rx[`FLD_SEQ_EN]; // R9 R10 R11
                                    ev_scan = ev;
                                end
                                `REG_TIMER: begin
                                    ev = scan_on && scan_in_gap; // R9 R10 R11
                                    ev_scan = ev;
                                end
                                default: ;
                            endcase
                        end
                    end
                    PH_RD: begin
                        if (s.regs[`REG_DIGITAL][`FLD_CRC_COM_EN] && (s.rd_static || s.addr == 4'hF)) begin
                            next_s.phase = PH_CRC_HI; // R17
                            next_s.shout = s.crc_tx[15:8];
                        end else begin
                            next_s.addr = s.rd_static ? s.addr : s.addr + 4'd1;
                            next_s.shout = reg_read(s, next_s.addr);
                            next_s.crc_tx = crc_byte(s.crc_tx, reg_read(s, next_s.addr));
                        end
                    end
                    PH_CRC_HI: begin
                        next_s.phase = PH_CRC_LO; // R17
                        next_s.shout = s.crc_tx[7:0];
                    end
                    PH_CRC_LO: begin
                        next_s.phase = PH_IGNORE;
                        next_s.drv.sdo_oe = 1'b0;
                    end
                    default: ;
                endcase
            end
            if (fall && s.got_rise && !id_bad && s.phase != PH_IGNORE) begin
                // Output bits change on the falling edge
                next_s.drv.sdo = s.shout[7]; // R12
                next_s.shout = s.shout << 1;
            end
        end
        // Background configuration checksum while locked
        if (locked) begin
            crc_n = crc_byte(s.cfg_acc, (s.cfg_idx == `REG_DATA || s.cfg_idx >= `REG_CFG_CRC_HI) ? 8'h00 : s.regs[s.cfg_idx]);
            next_s.cfg_idx = s.cfg_idx + 4'd1;
            next_s.cfg_acc = crc_n; // R18
            if (s.cfg_idx == 4'hF) begin
                next_s.cfg_acc = `CRC_INIT;
                next_s.cfg_crc = crc_n; // R18
                next_s.cfg_valid = 1'b1;
                if (s.cfg_valid && crc_n != s.cfg_crc) begin
                    next_s.cfg_err = 1'b1; // R18
                end
            end
        end else begin
            next_s.cfg_idx = 4'h0;
            next_s.cfg_acc = `CRC_INIT;
            next_s.cfg_valid = 1'b0;
        end
        // Restart sequencing
        case (s.rs)
            RS_WAIT: begin
                next_s.cnt = s.cnt + 16'd1;
                if (s.cnt >= `RESYNC_MIN_CYC - 16'd1 && (clock_aligned || s.cnt >= `RESYNC_MAX_CYC - 16'd1)) begin // R1 R8 R6
                    next_s.cnt = 16'd0;
                    next_s.rs = s.delayed ? RS_SETUP : RS_IDLE; // R5
                    next_s.ctl.conv_start = !s.delayed;
                    next_s.ctl.scan_restart = !s.delayed && s.whole_scan;
                    next_s.ctl.start_pulse = !s.delayed && s.regs[`REG_DIGITAL][`FLD_START_PULSE_EN]; // R7
                end
            end
            RS_SETUP: begin
                next_s.cnt = s.cnt + 16'd1;
                if (s.cnt == `ADC_SETUP_CYC - 16'd1) begin // R1
                    next_s.rs = RS_IDLE;
                    next_s.ctl.conv_start = 1'b1;
                    next_s.ctl.scan_restart = s.whole_scan;
                    next_s.ctl.start_pulse = s.regs[`REG_DIGITAL][`FLD_START_PULSE_EN]; // R7
                end
            end
            default: next_s.rs = RS_IDLE;
        endcase
        if (ev) begin
            next_s.rs = RS_WAIT; // R1
            next_s.cnt = 16'd0;
            next_s.ctl.conv_abort = 1'b1; // R1
            next_s.ctl.div_reset = 1'b1; // R6
            next_s.delayed = ev_delay;
            next_s.whole_scan = ev_scan; // R4
        end
        // Mode flag kept in its own flop so the output has no gate after the register
        next_s.single_ch = ~next_s.regs[`REG_SEQUENCER][`FLD_SEQ_EN]; // R9
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            // Whole serial port held in reset during power-on reset
            s <= '0; // R13
            s.cs_s1 <= 1'b1;
            s.cs_s2 <= 1'b1;
            s.cs_q <= 1'b1;
            s.regs <= reg_defaults();
            s.rs <= RS_IDLE;
            s.phase <= PH_CMD;
            s.single_ch <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    assign drv = s.drv;
    assign ctl = s.ctl;
    assign single_channel_mode = s.single_ch;
    assign start_pulse_enable = s.regs[`REG_DIGITAL][`FLD_START_PULSE_EN];
    assign config_checksum_error_flag = s.cfg_err;
    assign primary_settings_reg = s.regs[`REG_PRIMARY];
    assign bias_current_scale = s.regs[`REG_BIAS][`FLD_BIAS_HI:`FLD_BIAS_LO];

    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    chk_deselect_output_off: assert property (s.cs_s2 |=> !drv.sdo_oe) else $error("sdo driven while deselected"); // R14
    chk_abort_with_reset: assert property (ctl.conv_abort |-> ctl.div_reset) else $error("abort without divider reset"); // R6
    chk_no_early_start: assert property (ctl.conv_abort |=> !ctl.conv_start) else $error("start right after abort"); // R1
    chk_wait_bounded: assert property ($rose(s.rs == RS_WAIT) |-> ##[1:4] (s.rs != RS_WAIT || ev)) else $error("resync wait too long"); // R8
    chk_setup_length: assert property ((s.rs == RS_SETUP && s.cnt == 16'd0) |-> (s.rs == RS_SETUP) [*8]) else $error("setup ended early"); // R5
    chk_pulse_needs_enable: assert property (ctl.start_pulse |-> ctl.conv_start && start_pulse_enable) else $error("stray start pulse"); // R7
    chk_locked_no_write: assert property ((locked && s.phase == PH_WR && byte_done && s.addr != `REG_LOCK) |=> $stable(s.regs)) else $error("write while locked"); // R16
    chk_id_mismatch_quiet: assert property (id_bad |=> !drv.sdo_oe) else $error("output on after id mismatch"); // R22
    chk_status_leading_zero: assert property ((s.cs_q && !s.cs_s2) |=> drv.sdo_oe && !drv.sdo) else $error("status start not zero"); // R25
    chk_crc_err_sticky: assert property (s.cfg_err |=> s.cfg_err) else $error("checksum flag lost"); // R18
    chk_fast_quiet: assert property (byte_done && s.phase == PH_CMD && rx[1:0] == `CMD_FAST |=> !drv.sdo_oe) // R19
        else $error("output on after fast command");

    cov_delayed_restart: cover property (s.rs == RS_SETUP ##1 ctl.conv_start);
    cov_scan_restart: cover property (ctl.scan_restart);
    cov_crc_trailer: cover property (s.phase == PH_CRC_LO);
    cov_fast_start: cover property (ctl.fast_start);
    cov_checksum_error: cover property ($rose(s.cfg_err));
endmodule // spi_restart_ctrl

// ==== hdl/spi_restart_defs.svh ====
// Offsets, fields, reset values and timing counts of the serial port and restart control
`ifndef SPI_RESTART_DEFS_SVH
`define SPI_RESTART_DEFS_SVH
`define REG_DATA 4'h0
`define REG_PRIMARY 4'h1
`define REG_BIAS 4'h2
`define REG_DIGITAL 4'h3
`define REG_SEQUENCER 4'h7
`define REG_TIMER 4'h8
`define REG_RSVD_B 4'hB
`define REG_RSVD_C 4'hC
`define REG_LOCK 4'hD
`define REG_CFG_CRC_HI 4'hE
`define REG_CFG_CRC_LO 4'hF
`define FLD_BIAS_HI 7
`define FLD_BIAS_LO 6
`define FLD_START_PULSE_EN 1
`define FLD_CRC_COM_EN 0
`define FLD_SEQ_EN 7
`define UNLOCK_KEY 8'hA5
`define LOCK_RESET 8'hA5
`define REG_RESET 8'h00
`define CRC_INIT 16'h0000
`define CRC_POLY 16'h8005
`define CMD_FAST 2'h0
`define CMD_STATIC_RD 2'h1
`define CMD_INC_WR 2'h2
`define CMD_INC_RD 2'h3
`define FAST_START 4'hA
`define FAST_STANDBY 4'hB
`define FAST_ADC_OFF 4'hC
`define FAST_FULL_OFF 4'hD
`define FAST_FULL_RESET 4'hE
`define RESYNC_MIN_CYC 16'd2
`define RESYNC_MAX_CYC 16'd4
`define ADC_SETUP_CYC 16'd256
`endif

// ==== hdl/spi_restart_pkg.sv ====
// Types of the serial command port and restart control
package spi_restart_pkg;
    typedef struct packed {
        logic cs_n;
        logic sck;
        logic sdi;
    } spi_pins_t;
    typedef struct packed {
        logic sdo;
        logic sdo_oe;
    } spi_drive_t;
    typedef struct packed {
        logic conv_abort;
        logic div_reset;
        logic conv_start;
        logic scan_restart;
        logic start_pulse;
        logic fast_start;
        logic fast_standby;
        logic fast_adc_off;
    } conv_ctl_t;
    typedef enum logic [2:0] {PH_CMD, PH_WR, PH_RD, PH_CRC_HI, PH_CRC_LO, PH_IGNORE} phase_t;
    typedef enum logic [1:0] {RS_IDLE, RS_WAIT, RS_SETUP} rs_t;
    typedef struct packed {
        logic cs_s1, cs_s2, cs_q;
        logic sck_s1, sck_s2, sck_q;
        logic sdi_s1, sdi_s2;
        phase_t phase;
        logic got_rise;
        logic rd_static;
        logic [2:0] bitcnt;
        logic [7:0] shin;
        logic [7:0] shout;
        logic [3:0] addr;
        logic [15:0] crc_tx;
        logic [15:0][7:0] regs;
        logic [15:0] cfg_acc;
        logic [15:0] cfg_crc;
        logic [3:0] cfg_idx;
        logic cfg_valid;
        logic cfg_err;
        logic por_flag;
        rs_t rs;
        logic [15:0] cnt;
        logic delayed;
        logic whole_scan;
        logic single_ch;
        spi_drive_t drv;
        conv_ctl_t ctl;
    } state_t;
endpackage
